// ===== csi_pkg.sv
// Register map, field positions and timing constants of the charger status and interrupt block
package csi_pkg;
    // Register offsets on the serial register port
    localparam logic [7:0] ADDR_CHG_STATUS = 8'h01;
    localparam logic [7:0] ADDR_RAIL_STATUS = 8'h02;
    localparam logic [7:0] ADDR_CHG_MASK = 8'h03;
    localparam logic [7:0] ADDR_RAIL_MASK = 8'h04;
    localparam logic [7:0] ADDR_CHG_ACK = 8'h05;
    localparam logic [7:0] ADDR_RAIL_ACK = 8'h06;
    localparam logic [7:0] ADDR_CHG_CONFIG = 8'h07;

    // Reset values
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_MASK = 8'hff;
    localparam logic [7:0] RST_ACK = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h1b;
    localparam logic [7:0] READ_UNMAPPED = 8'hff;
    // Synchroniser idle levels: the battery lid pin rests high, so its flops start high
    localparam logic [18:0] SYNC_IDLE = 19'h00200;

    // Status bit classes
    localparam logic [7:0] CHG_EDGE_BITS = 8'h21;
    localparam logic [7:0] RAIL_EDGE_BITS = 8'he0;
    localparam logic [7:0] CHG_WRCLR_BITS = 8'h1e;
    localparam logic [7:0] RAIL_IMPL_BITS = 8'hef;

    // Charger status positions
    localparam int CHG_USB = 7;
    localparam int CHG_AC = 6;
    localparam int CHG_THERM = 5;
    localparam int CHG_TERM = 4;
    localparam int CHG_TAPER = 3;
    localparam int CHG_FAST_TO = 2;
    localparam int CHG_PRE_TO = 1;
    localparam int CHG_BATT_TEMP = 0;

    // Charger configuration positions
    localparam int CFG_AUTO_WAKE_DIS = 7;
    localparam int CFG_CHG_RESET = 6;
    localparam int CFG_TIMER_EN = 5;
    localparam int CFG_RATE_MSB = 4;
    localparam int CFG_RATE_LSB = 3;
    localparam int CFG_USB_500MA = 2;
    localparam int CFG_USB_ALLOW = 1;
    localparam int CFG_CHG_EN = 0;

    // Taper timer: 30 minutes at 125 MHz
    localparam longint TAPER_TIME_MIN = 30;
    localparam longint CLK_PERIOD_PS = 8000;
    localparam longint PS_PER_SEC = 64'he8d4a51000;
    localparam longint TAPER_CYCLES = (TAPER_TIME_MIN * 60 * PS_PER_SEC) / CLK_PERIOD_PS;
    localparam int TAPER_CNT_W = 38;
endpackage

// ===== csi_charger_status_regs.sv
// Charger and rail status, mask, acknowledge and charger configuration registers with open-drain interrupt
// Functional notes
// - Charger bits 7 and 6 read 1 while USB or wall source is valid.
// - Charger bit 5 reads 1 while charging is thermally suspended.
// - Charger bit 4 reads 1 once termination current stopped charging.
// - Bit 3 follows taper comparator, or 30-minute taper timer when timers enabled.
// - Charger bits 3 to 1 read 1 when their timer expired.
// - Charger bit 0 reads 1 while battery temperature is out of range.
// - Writing 0 to bits 1 to 4 clears them and restarts the charger; others ignored.
// - Any unmasked, unacknowledged charger status bit at 1 activates the interrupt.
// - Rail bit 7 reads 1 after the power-off button request.
// - Rail bit 6 reads 1 while the battery lid pin is low.
// - Rail bit 5 flags supply lockout; rail bit 4 always reads 0.
// - Rail bits 3 and 2 flag linear regulators out of regulation when enabled.
// - Rail bits 1 and 0 flag converters; bit 0 also core-off in low power.
// - A rising rail status bit drives the interrupt low unless masked.
// - Mask bits block matching status bits; both masks reset to all ones.
// - Acknowledged bits no longer reach the interrupt output.
// - Acknowledge bits self-clear with their status bit; host cannot write them.
// - Auto-wake disable at 0 forces ON when a source is valid above lockout.
// - Config bit 6 clears charger timers; host sets then clears it.
// - Config bits 4:3 select 25, 50, 75 or 100 percent charge current.
// - Config bit 1 at 0 blocks USB charging; bit 2 picks 100 or 500 mA.
// - Config bit 0 at 0 prohibits all charging.
// - Reading a status register acknowledges every bit that reads 1.
// - Charger bits 5,0 and rail bits 7-5 edge-set; others level-set.
`timescale 1ns/1ps
module csi_charger_status_regs #(
    parameter longint TAPER_TIMEOUT_CYCLES = csi_pkg::TAPER_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    // Register port from the serial engine
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Charger condition inputs (analog side, asynchronous)
    input wire logic USB_SOURCE_VALID,
    input wire logic AC_SOURCE_VALID,
    input wire logic THERMAL_SUSPEND,
    input wire logic TERM_CURRENT_REACHED,
    input wire logic TAPER_COMPARATOR,
    input wire logic FAST_CHARGE_TIMEOUT,
    input wire logic PRECHARGE_TIMEOUT,
    input wire logic BATT_TEMP_FAULT,
    // Rail condition inputs (asynchronous)
    input wire logic POWER_OFF_BUTTON,
    input wire logic BATTERY_LID_INPUT_N,
    input wire logic SUPPLY_LOW_LOCKOUT,
    input wire logic LINEAR_REG_SECOND_BAD,
    input wire logic LINEAR_REG_FIRST_BAD,
    input wire logic MAIN_CONV_BAD,
    input wire logic CORE_CONV_BAD,
    input wire logic LINEAR_REG_SECOND_EN,
    input wire logic LINEAR_REG_FIRST_EN,
    input wire logic CORE_OFF_IN_LOW_POWER,
    input wire logic LOW_POWER_MODE,
    // Interrupt pin, open drain
    output logic INT_N_O,
    output logic INT_N_OE,
    // Charger control outputs
    output logic CHARGER_RESTART,
    output logic CHARGER_TIMER_CLEAR,
    output logic AUTO_ON_REQUEST,
    output logic [2:0] CHARGE_CURRENT_QUARTERS,
    output logic USB_CHARGE_ALLOWED,
    output logic USB_500MA_LIMIT,
    output logic CHARGE_ENABLE
);
    import csi_pkg::*;

    logic [7:0] chg_status;
    logic [7:0] rail_status;
    logic [7:0] chg_mask;
    logic [7:0] rail_mask;
    logic [7:0] chg_ack;
    logic [7:0] rail_ack;
    logic [7:0] charger_config;
    logic [18:0] sync_a;
    logic [18:0] sync_b;
    logic [7:0] chg_src;
    logic [7:0] rail_src;
    logic [7:0] chg_src_d;
    logic [7:0] rail_src_d;
    logic [7:0] next_chg_status;
    logic [7:0] next_rail_status;
    logic [7:0] next_chg_ack;
    logic [7:0] next_rail_ack;
    logic [7:0] chg_wr_clear;
    logic [TAPER_CNT_W-1:0] taper_count;
    logic taper_expired;
    logic taper_q;
    logic rd_chg;
    logic rd_rail;
    logic wr_chg;
    logic int_active;

    // Rate select to quarters of the resistor-set maximum: 00 -> 1/4 .. 11 -> 4/4
    function automatic logic [2:0] rate_quarters(input logic [1:0] sel);
        rate_quarters = {1'b0, sel} + 3'h1;
    endfunction

    // Mask of bits whose pending interrupt is live
    function automatic logic [7:0] live_bits(input logic [7:0] st, input logic [7:0] mk, input logic [7:0] ak);
        live_bits = st & ~mk & ~ak;
    endfunction

    // Two-flop synchroniser for every asynchronous condition input
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sync_a <= SYNC_IDLE; // Zero here would fake a lid edge after reset
            sync_b <= SYNC_IDLE;
        end else begin
            sync_a <= {USB_SOURCE_VALID, AC_SOURCE_VALID, THERMAL_SUSPEND, TERM_CURRENT_REACHED,
                       TAPER_COMPARATOR, FAST_CHARGE_TIMEOUT, PRECHARGE_TIMEOUT, BATT_TEMP_FAULT,
                       POWER_OFF_BUTTON, BATTERY_LID_INPUT_N, SUPPLY_LOW_LOCKOUT,
                       LINEAR_REG_SECOND_BAD, LINEAR_REG_FIRST_BAD, MAIN_CONV_BAD, CORE_CONV_BAD,
                       LINEAR_REG_SECOND_EN, LINEAR_REG_FIRST_EN, CORE_OFF_IN_LOW_POWER, LOW_POWER_MODE};
            sync_b <= sync_a;
        end
    end

    assign taper_q = sync_b[14];

    // Register port decode
    assign rd_chg = REG_RD && (REG_ADDR == ADDR_CHG_STATUS);
    assign rd_rail = REG_RD && (REG_ADDR == ADDR_RAIL_STATUS);
    assign wr_chg = REG_WR && (REG_ADDR == ADDR_CHG_STATUS);
    assign chg_wr_clear = wr_chg ? (~REG_WDATA & CHG_WRCLR_BITS) : 8'h00;

    // Taper timer runs while the comparator trips and timers are enabled
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            taper_count <= '0;
        end else if (!taper_q || !charger_config[CFG_TIMER_EN] || charger_config[CFG_CHG_RESET]
                     || CHARGER_RESTART) begin
            taper_count <= '0;
        end else if (!taper_expired) begin
            taper_count <= taper_count + 1'b1;
        end
    end

    assign taper_expired = (taper_count >= TAPER_CNT_W'(TAPER_TIMEOUT_CYCLES - 1));

    // Condition sources in status bit order
    always_comb begin
        chg_src = sync_b[18:11];
        chg_src[CHG_TAPER] = charger_config[CFG_TIMER_EN] ? taper_expired : taper_q;
        rail_src = {sync_b[10], ~sync_b[9], sync_b[8], 1'b0,
                    sync_b[7] & sync_b[3], sync_b[6] & sync_b[2],
                    sync_b[5], sync_b[4] | (sync_b[1] & sync_b[0])};
    end

    // Previous source levels for rising-edge capture
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            chg_src_d <= '0;
            rail_src_d <= '0;
        end else begin
            chg_src_d <= chg_src;
            rail_src_d <= rail_src;
        end
    end

    // Next status: edge bits hold until read and source low, level bits follow source
    always_comb begin
        next_chg_status = ((chg_status | (chg_src & ~chg_src_d)) & ~(~chg_src & chg_ack) & CHG_EDGE_BITS)
                        | (chg_src & ~chg_wr_clear & ~CHG_EDGE_BITS);
        next_rail_status = (((rail_status | (rail_src & ~rail_src_d)) & ~(~rail_src & rail_ack) & RAIL_EDGE_BITS)
                         | (rail_src & ~RAIL_EDGE_BITS)) & RAIL_IMPL_BITS;
        // A read acknowledges bits reading 1; an ack drops once its status is gone
        next_chg_ack = (chg_ack | (rd_chg ? chg_status : 8'h00)) & next_chg_status;
        next_rail_ack = (rail_ack | (rd_rail ? rail_status : 8'h00)) & next_rail_status;
    end

    // Status and acknowledge storage
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            chg_status <= RST_STATUS;
            rail_status <= RST_STATUS;
            chg_ack <= RST_ACK;
            rail_ack <= RST_ACK;
        end else begin
            chg_status <= next_chg_status;
            rail_status <= next_rail_status;
            chg_ack <= next_chg_ack;
            rail_ack <= next_rail_ack;
        end
    end

    // Writable registers; status and ack registers ignore other writes
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            chg_mask <= RST_MASK;
            rail_mask <= RST_MASK;
            charger_config <= RST_CONFIG;
        end else if (REG_WR) begin
            if (REG_ADDR == ADDR_CHG_MASK) begin
                chg_mask <= REG_WDATA;
            end
            if (REG_ADDR == ADDR_RAIL_MASK) begin
                rail_mask <= REG_WDATA;
            end
            if (REG_ADDR == ADDR_CHG_CONFIG) begin
                charger_config <= REG_WDATA;
            end
        end
    end

    // Charger restart pulse when software clears a timeout or termination bit
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            CHARGER_RESTART <= 1'b0;
        end else begin
            CHARGER_RESTART <= |chg_wr_clear;
        end
    end

    // Read data is captured at the strobe so later events are not lost during shift-out
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                ADDR_CHG_STATUS: REG_RDATA <= chg_status;
                ADDR_RAIL_STATUS: REG_RDATA <= rail_status;
                ADDR_CHG_MASK: REG_RDATA <= chg_mask;
                ADDR_RAIL_MASK: REG_RDATA <= rail_mask;
                ADDR_CHG_ACK: REG_RDATA <= chg_ack;
                ADDR_RAIL_ACK: REG_RDATA <= rail_ack;
                ADDR_CHG_CONFIG: REG_RDATA <= charger_config;
                default: REG_RDATA <= READ_UNMAPPED;
            endcase
        end
    end

    // Interrupt: only unmasked, unacknowledged bits pull the pin low
    assign int_active = |live_bits(chg_status, chg_mask, chg_ack)
                      | |live_bits(rail_status, rail_mask, rail_ack);
    assign INT_N_O = 1'b0;
    assign INT_N_OE = int_active;

    // Charger control decode from the configuration register
    assign CHARGER_TIMER_CLEAR = charger_config[CFG_CHG_RESET];
    assign AUTO_ON_REQUEST = !charger_config[CFG_AUTO_WAKE_DIS] && (chg_status[CHG_USB] || chg_status[CHG_AC])
                           && !sync_b[8];
    assign CHARGE_CURRENT_QUARTERS = rate_quarters(charger_config[CFG_RATE_MSB:CFG_RATE_LSB]);
    assign CHARGE_ENABLE = charger_config[CFG_CHG_EN];
    assign USB_CHARGE_ALLOWED = charger_config[CFG_CHG_EN] && charger_config[CFG_USB_ALLOW];
    // 500 mA choice only matters while USB charging is allowed
    assign USB_500MA_LIMIT = USB_CHARGE_ALLOWED && charger_config[CFG_USB_500MA];

    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    chk_masks_block_int: assert property ((chg_mask == 8'hff && rail_mask == 8'hff) |-> !INT_N_OE)
        else $error("interrupt active with all masks set");

    // A status read acknowledges exactly the bits it returned
    chk_read_acks: assert property (rd_chg
        |=> ((chg_ack & $past(chg_status)) == ($past(chg_status) & chg_status)))
        else $error("charger status read did not acknowledge set bits");
    chk_rail_acks: assert property (rd_rail
        |=> ((rail_ack & $past(rail_status)) == ($past(rail_status) & rail_status)))
        else $error("rail status read did not acknowledge set bits");
    chk_ack_subset: assert property (((chg_ack & ~chg_status) == 8'h00)
        && ((rail_ack & ~rail_status) == 8'h00))
        else $error("acknowledge bit without status bit");
    chk_ack_frees_int: assert property ((rd_chg && rail_status == 8'h00 && !$changed(chg_src)
                                          && (chg_src & ~CHG_EDGE_BITS) == (chg_status & ~CHG_EDGE_BITS))
                                         |=> !INT_N_OE)
        else $error("interrupt still active after full acknowledge");
    chk_bit4_zero: assert property (rail_status[4] == 1'b0)
        else $error("unimplemented rail bit set");
    chk_wr_restart: assert property ((wr_chg && (~REG_WDATA & CHG_WRCLR_BITS) != 8'h00)
                                      |=> CHARGER_RESTART && (chg_status & $past(chg_wr_clear)) == 8'h00)
        else $error("write clear failed");
    // A restart pulse only ever follows a clearing write
    chk_restart_cause: assert property (CHARGER_RESTART |-> $past(wr_chg))
        else $error("charger restart without a clearing write");

    chk_edge_capture: assert property ($rose(chg_src[CHG_THERM]) |=> chg_status[CHG_THERM] [*2])
        else $error("edge status bit not captured");
    // Unacknowledged edge bits must survive a falling source, or a short event is lost
    chk_chg_edge_hold: assert property (1'b1
        |=> (chg_status & $past(chg_status & ~chg_ack & CHG_EDGE_BITS))
            == $past(chg_status & ~chg_ack & CHG_EDGE_BITS))
        else $error("charger edge bit dropped before acknowledge");
    chk_rail_edge_hold: assert property (1'b1
        |=> (rail_status & $past(rail_status & ~rail_ack & RAIL_EDGE_BITS))
            == $past(rail_status & ~rail_ack & RAIL_EDGE_BITS))
        else $error("rail edge bit dropped before acknowledge");
    // Level bits mirror the synchronised source one cycle on; a write clear wins for that cycle
    chk_chg_level: assert property (1'b1
        |=> (chg_status & ~CHG_EDGE_BITS) == ($past(chg_src) & ~$past(chg_wr_clear) & ~CHG_EDGE_BITS))
        else $error("charger level bit does not follow its source");
    chk_rail_level: assert property (1'b1
        |=> (rail_status & ~RAIL_EDGE_BITS & RAIL_IMPL_BITS)
            == ($past(rail_src) & ~RAIL_EDGE_BITS & RAIL_IMPL_BITS))
        else $error("rail level bit does not follow its source");

    chk_taper_direct: assert property ((!charger_config[CFG_TIMER_EN] && !wr_chg)
                                        |=> chg_status[CHG_TAPER] == $past(taper_q))
        else $error("taper bit does not follow comparator");
    // With timers on, the taper bit stays low until the full timeout has run
    chk_taper_timer: assert property ((charger_config[CFG_TIMER_EN] && !taper_expired)
        |=> !chg_status[CHG_TAPER])
        else $error("taper bit set before its timeout");
    chk_timer_clear: assert property (charger_config[CFG_CHG_RESET] |=> taper_count == '0)
        else $error("taper timer not cleared by charger reset");

    // Mask and configuration writes land on the next cycle
    chk_chg_mask_wr: assert property ((REG_WR && REG_ADDR == ADDR_CHG_MASK)
        |=> chg_mask == $past(REG_WDATA))
        else $error("charger mask write lost");
    chk_rail_mask_wr: assert property ((REG_WR && REG_ADDR == ADDR_RAIL_MASK)
        |=> rail_mask == $past(REG_WDATA))
        else $error("rail mask write lost");
    chk_config_wr: assert property ((REG_WR && REG_ADDR == ADDR_CHG_CONFIG)
        |=> charger_config == $past(REG_WDATA))
        else $error("configuration write lost");

    chk_usb_rate: assert property (USB_500MA_LIMIT |-> USB_CHARGE_ALLOWED && CHARGE_ENABLE)
        else $error("USB 500 mA without USB charging");
    // Clearing USB allow or charge enable must shut every USB charging output
    chk_usb_block: assert property ((!charger_config[CFG_USB_ALLOW] || !charger_config[CFG_CHG_EN])
        |-> !USB_CHARGE_ALLOWED && !USB_500MA_LIMIT)
        else $error("USB charging output with USB or charging disabled");
    chk_charge_off: assert property (!charger_config[CFG_CHG_EN] |-> !CHARGE_ENABLE)
        else $error("charge enable output with charging disabled");
    chk_auto_wake: assert property (AUTO_ON_REQUEST |-> !charger_config[CFG_AUTO_WAKE_DIS])
        else $error("auto-on with auto-wake disabled");
    chk_lockout_wake: assert property (sync_b[8] |-> !AUTO_ON_REQUEST)
        else $error("auto-on request during supply lockout");
    chk_unmapped_ff: assert property ((REG_RD && REG_ADDR > ADDR_CHG_CONFIG) |=> REG_RDATA == READ_UNMAPPED)
        else $error("unmapped read not all ones");

    cov_int_raised: cover property ($rose(INT_N_OE));
    cov_read_ack: cover property (rd_chg && chg_status != 8'h00 ##1 chg_ack != 8'h00);
    cov_taper_expire: cover property ($rose(taper_expired));
    cov_rail_edge: cover property ($rose(rail_status[7]) ##[1:20] rd_rail);
    cov_write_clear: cover property ($rose(CHARGER_RESTART));
endmodule

// ===== csi_host_model.sv
// Host-side model that drives the register port of the status block
`timescale 1ns/1ps
module csi_host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    import csi_pkg::*;
    // Idle bus after reset
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // One strobe cycle per byte; idle lines show the inverse so stale values never match
    task automatic xfer(input logic [7:0] addr, input logic [7:0] data, input logic is_wr, output logic [7:0] rdata);
        @(posedge clk);
        #1;
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = is_wr;
        reg_rd = !is_wr;
        @(posedge clk);
        #1;
        rdata = reg_rdata; // Registered data lands one cycle after the strobe
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~addr;
        reg_wdata = ~data;
    endtask
    // Charger restart is a set followed by a clear of the config bit
    task automatic restart(input logic [7:0] cfg);
        logic [7:0] unused;
        xfer(ADDR_CHG_CONFIG, cfg | 8'h40, 1'b1, unused);
        xfer(ADDR_CHG_CONFIG, cfg & 8'hbf, 1'b1, unused);
    endtask
endmodule

// ===== csi_charger_status_regs_tb.sv
// Self-checking bench for the charger status and interrupt registers
`timescale 1ns/1ps
module csi_charger_status_regs_tb;
    import csi_pkg::*;
    localparam longint TAPER_N = 20;
    logic core_clk, resetn, reg_wr, reg_rd, en1, en2, core_off, low_pwr;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, chg_in, rail_in, cfg;
    logic int_n_o, int_n_oe, restart_p, timer_clr, auto_on, usb_ok, usb_500, chg_en;
    logic [2:0] quarters;
    int errors, n_compared, cycles;
    logic [7:0] m_reg [0:255];
    int unsigned seed_dummy;
    csi_charger_status_regs #(.TAPER_TIMEOUT_CYCLES(TAPER_N)) csi_charger_status_regs_inst (
        .CORE_CLK(core_clk), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .USB_SOURCE_VALID(chg_in[7]), .AC_SOURCE_VALID(chg_in[6]),
        .THERMAL_SUSPEND(chg_in[5]), .TERM_CURRENT_REACHED(chg_in[4]), .TAPER_COMPARATOR(chg_in[3]),
        .FAST_CHARGE_TIMEOUT(chg_in[2]), .PRECHARGE_TIMEOUT(chg_in[1]), .BATT_TEMP_FAULT(chg_in[0]),
        .POWER_OFF_BUTTON(rail_in[7]), .BATTERY_LID_INPUT_N(~rail_in[6]), .SUPPLY_LOW_LOCKOUT(rail_in[5]),
        .LINEAR_REG_SECOND_BAD(rail_in[3]), .LINEAR_REG_FIRST_BAD(rail_in[2]), .MAIN_CONV_BAD(rail_in[1]),
        .CORE_CONV_BAD(rail_in[0]), .LINEAR_REG_SECOND_EN(en2), .LINEAR_REG_FIRST_EN(en1),
        .CORE_OFF_IN_LOW_POWER(core_off), .LOW_POWER_MODE(low_pwr), .INT_N_O(int_n_o), .INT_N_OE(int_n_oe),
        .CHARGER_RESTART(restart_p), .CHARGER_TIMER_CLEAR(timer_clr), .AUTO_ON_REQUEST(auto_on),
        .CHARGE_CURRENT_QUARTERS(quarters), .USB_CHARGE_ALLOWED(usb_ok), .USB_500MA_LIMIT(usb_500),
        .CHARGE_ENABLE(chg_en));
    csi_host_model csi_host_model_inst (.clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // Free-running core clock, 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Hang guard; the whole run needs well under 3000 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Writes update the register model only where the host may write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        csi_host_model_inst.xfer(a, d, 1'b1, r);
        if (a == ADDR_CHG_MASK || a == ADDR_RAIL_MASK || a == ADDR_CHG_CONFIG) m_reg[a] = d;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] r;
        csi_host_model_inst.xfer(a, 8'h00, 1'b0, r);
        check(r, exp);
    endtask
    // Raise one source, see the interrupt, acknowledge by read, drop it, see status and ack clear
    task automatic event_bit(input logic [7:0] rg, input int b);
        logic [7:0] bitv;
        bitv = 8'h01 << b;
        if (rg == ADDR_CHG_STATUS) chg_in = chg_in | bitv;
        else rail_in = rail_in | bitv;
        wait_cyc(5);
        check({7'h00, int_n_oe}, 8'h01);
        rdc(rg, bitv);
        check({7'h00, int_n_oe}, 8'h00);
        rdc(rg + 8'h04, bitv);
        chg_in = 8'h00;
        rail_in = 8'h00;
        wait_cyc(5);
        rdc(rg + 8'h04, 8'h00);
        rdc(rg, 8'h00);
    endtask
    initial begin
        {core_off, low_pwr, errors, n_compared, cycles} = '0;
        {chg_in, rail_in, cfg} = '0;
        {en1, en2} = 2'b11;
        for (int i = 0; i < 256; i++) m_reg[i] = READ_UNMAPPED;
        {m_reg[1], m_reg[2], m_reg[5], m_reg[6]} = '0;
        {m_reg[3], m_reg[4], m_reg[7]} = {8'hff, 8'hff, 8'h1b};
        resetn = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        seed_dummy = $urandom(69274);
        // Reset values, unmapped reads and idle outputs
        for (int a = 0; a < 9; a++) rdc(a[7:0], m_reg[a]);
        rdc(8'h7f, 8'hff);
        check({int_n_o, int_n_oe, chg_en, usb_ok, usb_500, quarters}, 8'h34);
        $display("test reset done");
        // Every implemented status bit of both registers with all masks open
        wr(ADDR_CHG_MASK, 8'h00);
        wr(ADDR_RAIL_MASK, 8'h00);
        rdc(ADDR_RAIL_MASK, m_reg[ADDR_RAIL_MASK]);
        for (int b = 0; b < 8; b++) event_bit(ADDR_CHG_STATUS, b);
        for (int b = 0; b < 8; b++) if (b != 4) event_bit(ADDR_RAIL_STATUS, b);
        core_off = 1'b1;
        low_pwr = 1'b1;
        wait_cyc(5);
        rdc(ADDR_RAIL_STATUS, 8'h01);
        {core_off, low_pwr, en1, en2} = 4'b0000;
        rail_in[3:2] = 2'b11;
        wait_cyc(5);
        rdc(ADDR_RAIL_STATUS, 8'h00);
        rail_in[3:2] = 2'b00;
        {en1, en2} = 2'b11;
        $display("test events done");
        // A masked event is held and shows once unmasked
        wr(ADDR_CHG_MASK, 8'hff);
        chg_in[4] = 1'b1;
        wait_cyc(5);
        check({7'h00, int_n_oe}, 8'h00);
        wr(ADDR_CHG_MASK, 8'hef);
        check({7'h00, int_n_oe}, 8'h01);
        rdc(ADDR_CHG_STATUS, 8'h10);
        check({7'h00, int_n_oe}, 8'h00);
        chg_in[4] = 1'b0;
        chg_in[2] = 1'b1;
        wait_cyc(5);
        // Write-clear of timeout bits, read-only ack and rail status
        wr(ADDR_CHG_STATUS, 8'hff);
        check({7'h00, restart_p}, 8'h00);
        wr(ADDR_CHG_STATUS, 8'h00);
        check({7'h00, restart_p}, 8'h01);
        wr(ADDR_RAIL_STATUS, 8'hff);
        wr(ADDR_CHG_ACK, 8'hff);
        rdc(ADDR_CHG_ACK, 8'h00);
        rdc(ADDR_RAIL_STATUS, 8'h00);
        chg_in[2] = 1'b0;
        wait_cyc(5);
        $display("test mask and write done");
        // Config fields against the control outputs, every rate code
        for (int i = 0; i < 8; i++) begin
            cfg = (8'($urandom()) & 8'he7) | 8'((i % 4) << 3);
            wr(ADDR_CHG_CONFIG, cfg);
            rdc(ADDR_CHG_CONFIG, m_reg[ADDR_CHG_CONFIG]);
            check({5'h00, quarters}, 8'(cfg[4:3]) + 8'h01);
            check({5'h00, usb_ok, usb_500, chg_en}, {5'h00, cfg[0] & cfg[1], &cfg[2:0], cfg[0]});
            check({6'h00, timer_clr, auto_on}, {6'h00, cfg[6], 1'b0});
        end
        $display("test config done");
        // Taper timer delay and its clearing by a charger restart
        wr(ADDR_CHG_CONFIG, 8'h3b);
        chg_in[3] = 1'b1;
        wait_cyc(8);
        rdc(ADDR_CHG_STATUS, 8'h00);
        wait_cyc(30);
        rdc(ADDR_CHG_STATUS, 8'h08);
        csi_host_model_inst.restart(8'h3b);
        rdc(ADDR_CHG_STATUS, 8'h00);
        chg_in[3] = 1'b0;
        wr(ADDR_CHG_CONFIG, 8'h1b);
        $display("test taper done");
        // Auto-wake follows source, disable bit and lockout
        chg_in[7] = 1'b1;
        wait_cyc(5);
        check({7'h00, auto_on}, 8'h01);
        wr(ADDR_CHG_CONFIG, 8'h9b);
        check({7'h00, auto_on}, 8'h00);
        wr(ADDR_CHG_CONFIG, 8'h1b);
        rail_in[5] = 1'b1;
        wait_cyc(5);
        check({7'h00, auto_on}, 8'h00);
        $display("test auto wake done");
        end_sim();
    end
endmodule
